// ### hdl/capacity_alarm_flags.sv
// Capacity alarm block: charge integration, threshold flags, AHB-Lite registers.
// Assumes one AHB-Lite master doing single word transfers; sense pins are asynchronous.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module capacity_alarm_flags (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sense_positive_input,
   input wire logic sense_negative_input,
   output logic low_capacity_flag,
   output logic final_capacity_flag
);
   typedef struct packed {
      logic run;
      logic [15:0] low_capacity_set_level;
      logic [15:0] final_capacity_set_level;
      logic [15:0] final_capacity_clear_level;
      logic [15:0] remaining_charge_value;
      logic [31:0] sample_div;
      logic [31:0] div_cnt;
      logic sample_en;
      logic low_flag;
      logic final_flag;
      logic dir_charge;
      logic update;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } state_t;
   state_t st_reg, st_next;

   logic pos_sync;
   logic neg_sync;
   logic step_up;
   logic step_down;
   logic access;
   logic [7:0] addr_lo;

   // Sense pins enter the clock domain through two flops each
   sync2 u_sync_pos (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(sense_positive_input),
      .q(pos_sync)
   );
   sync2 u_sync_neg (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(sense_negative_input),
      .q(neg_sync)
   );

   // Positive side high means charge current, negative side high means discharge
   charge_counter u_counter (
      .hclk(hclk),
      .hresetn(hresetn),
      .sample_en(st_reg.sample_en),
      .charging(pos_sync),
      .discharging(neg_sync),
      .step_up(step_up),
      .step_down(step_down)
   );

   // Address phase qualifier
   assign access = hsel && hready && htrans[1];
   assign addr_lo = haddr[7:0];

   // Next-state logic for bus, divider, charge value and flags
   always_comb begin
      st_next = st_reg;
      st_next.sample_en = 1'b0;
      st_next.update = 1'b0;
      // Sample divider
      if (st_reg.run) begin
         if (st_reg.div_cnt >= st_reg.sample_div - 32'h0000_0001) begin
            st_next.div_cnt = 32'h0000_0000;
            st_next.sample_en = 1'b1;
         end else begin
            st_next.div_cnt = st_reg.div_cnt + 32'h0000_0001;
         end
      end
      // Charge integration
      if (step_up && st_reg.remaining_charge_value != 16'hFFFF) begin
         st_next.remaining_charge_value = st_reg.remaining_charge_value + 16'h0001;
         st_next.dir_charge = 1'b1;
         st_next.update = 1'b1;
      end else if (step_down && st_reg.remaining_charge_value != 16'h0000) begin
         st_next.remaining_charge_value = st_reg.remaining_charge_value - 16'h0001;
         st_next.dir_charge = 1'b0;
         st_next.update = 1'b1;
      end
      // Threshold checks on each updated value
      if (st_reg.update) begin
         if (st_reg.remaining_charge_value < st_reg.low_capacity_set_level) begin
            st_next.low_flag = 1'b1;
         end else if (st_reg.remaining_charge_value > st_reg.low_capacity_set_level) begin
            st_next.low_flag = 1'b0;
         end
         if (st_reg.final_flag &&
             st_reg.remaining_charge_value > st_reg.final_capacity_clear_level) begin
            st_next.final_flag = 1'b0;
         end else if (st_reg.final_capacity_set_level != capacity_alarm_pkg::final_disable &&
                      st_reg.remaining_charge_value < st_reg.final_capacity_set_level) begin
            st_next.final_flag = 1'b1;
         end
      end
      // Write data phase
      if (st_reg.wr_pend) begin
         st_next.wr_pend = 1'b0;
         case (st_reg.wr_addr)
            capacity_alarm_pkg::ctrl_off: begin
               st_next.run = hwdata[capacity_alarm_pkg::ctrl_run_bit];
            end
            capacity_alarm_pkg::low_set_off: begin
               st_next.low_capacity_set_level = hwdata[15:0];
            end
            capacity_alarm_pkg::final_set_off: begin
               st_next.final_capacity_set_level = hwdata[15:0];
            end
            capacity_alarm_pkg::final_clear_off: begin
               st_next.final_capacity_clear_level = hwdata[15:0];
            end
            capacity_alarm_pkg::charge_off: begin
               // Load from software re-runs the checks
               st_next.remaining_charge_value = hwdata[15:0];
               st_next.update = 1'b1;
            end
            capacity_alarm_pkg::load_off: begin
               st_next.sample_div = (hwdata == 32'h0000_0000) ? 32'h0000_0001 : hwdata;
            end
            default: begin
            end
         endcase
      end
      // Address phase: capture write, prepare read data
      if (access) begin
         st_next.rdata = 32'h0000_0000;
         if (hwrite) begin
            st_next.wr_pend = 1'b1;
            st_next.wr_addr = addr_lo;
         end else begin
            case (addr_lo)
               capacity_alarm_pkg::ctrl_off: begin
                  st_next.rdata[capacity_alarm_pkg::ctrl_run_bit] = st_reg.run;
               end
               capacity_alarm_pkg::low_set_off: begin
                  st_next.rdata[15:0] = st_reg.low_capacity_set_level;
               end
               capacity_alarm_pkg::final_set_off: begin
                  st_next.rdata[15:0] = st_reg.final_capacity_set_level;
               end
               capacity_alarm_pkg::final_clear_off: begin
                  st_next.rdata[15:0] = st_reg.final_capacity_clear_level;
               end
               capacity_alarm_pkg::charge_off: begin
                  st_next.rdata[15:0] = st_reg.remaining_charge_value;
               end
               capacity_alarm_pkg::status_off: begin
                  st_next.rdata[capacity_alarm_pkg::status_low_bit] = st_reg.low_flag;
                  st_next.rdata[capacity_alarm_pkg::status_final_bit] = st_reg.final_flag;
                  st_next.rdata[capacity_alarm_pkg::status_dir_bit] = st_reg.dir_charge;
               end
               capacity_alarm_pkg::load_off: begin
                  st_next.rdata = st_reg.sample_div;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // State register; flags clear at reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg.run <= 1'b0;
         st_reg.low_capacity_set_level <= capacity_alarm_pkg::low_set_rst;
         st_reg.final_capacity_set_level <= capacity_alarm_pkg::final_set_rst;
         st_reg.final_capacity_clear_level <= capacity_alarm_pkg::final_clear_rst;
         st_reg.remaining_charge_value <= capacity_alarm_pkg::charge_rst;
         st_reg.sample_div <= capacity_alarm_pkg::sample_div_rst;
         st_reg.div_cnt <= 32'h0000_0000;
         st_reg.sample_en <= 1'b0;
         st_reg.low_flag <= 1'b0;
         st_reg.final_flag <= 1'b0;
         st_reg.dir_charge <= 1'b0;
         st_reg.update <= 1'b0;
         st_reg.wr_pend <= 1'b0;
         st_reg.wr_addr <= 8'h00;
         st_reg.rdata <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
      end
   end

   // Zero-wait-state slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_reg.rdata;
   assign low_capacity_flag = st_reg.low_flag;
   assign final_capacity_flag = st_reg.final_flag;
endmodule

// ### hdl/capacity_alarm_pkg.sv
// Constants for the capacity alarm block: register map, reset values, counts.
// Assumes an AHB-Lite slave with 32-bit data and one aligned word per register.
package capacity_alarm_pkg;
   // Register byte offsets
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] low_set_off = 8'h04;
   localparam logic [7:0] final_set_off = 8'h08;
   localparam logic [7:0] final_clear_off = 8'h0C;
   localparam logic [7:0] charge_off = 8'h10;
   localparam logic [7:0] status_off = 8'h14;
   localparam logic [7:0] load_off = 8'h18;
   // Field positions
   localparam int ctrl_run_bit = 0;
   localparam int status_low_bit = 0;
   localparam int status_final_bit = 1;
   localparam int status_dir_bit = 2;
   // Reset values, mAh
   localparam logic [15:0] low_set_rst = 16'h0096;
   localparam logic [15:0] final_set_rst = 16'h004B;
   localparam logic [15:0] final_clear_rst = 16'h0064;
   localparam logic [15:0] charge_rst = 16'h0000;
   // Value that disables the final warning (minus one)
   localparam logic [15:0] final_disable = 16'hFFFF;
   // Sense samples accumulated per mAh step; hclk cycles per sample at reset
   localparam int samples_per_mah = 16;
   localparam logic [31:0] sample_div_rst = 32'h0000_0100;
endpackage

// ### hdl/sync2.sv
// Two-flop synchroniser for one level.
// Assumes a single clock hclk and async active-low reset.
`timescale 1ns/1ns
module sync2 (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic d,
   output logic q
);
   logic meta_reg;
   // First flop feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ### hdl/charge_counter.sv
// Coulomb step counter: turns sense comparator pulses into mAh steps.
// Assumes synchronised direction inputs and a one-cycle sample enable.
`timescale 1ns/1ns
module charge_counter #(
   parameter int steps = capacity_alarm_pkg::samples_per_mah
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sample_en,
   input wire logic charging,
   input wire logic discharging,
   output logic step_up,
   output logic step_down
);
   typedef struct packed {
      logic signed [7:0] acc;
      logic up;
      logic down;
   } cnt_t;
   cnt_t cnt_reg, cnt_next;
   localparam logic signed [7:0] lim = 8'(steps);
   // Integrate samples; emit a step each time the count reaches a full mAh
   always_comb begin
      cnt_next = cnt_reg;
      cnt_next.up = 1'b0;
      cnt_next.down = 1'b0;
      if (sample_en && charging && !discharging) begin
         if (cnt_reg.acc == lim - 8'sd1) begin
            cnt_next.acc = 8'sd0;
            cnt_next.up = 1'b1;
         end else begin
            cnt_next.acc = cnt_reg.acc + 8'sd1;
         end
      end else if (sample_en && discharging && !charging) begin
         if (cnt_reg.acc == -lim + 8'sd1) begin
            cnt_next.acc = 8'sd0;
            cnt_next.down = 1'b1;
         end else begin
            cnt_next.acc = cnt_reg.acc - 8'sd1;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   assign step_up = cnt_reg.up;
   assign step_down = cnt_reg.down;
endmodule

// ### verif/capacity_alarm_chk.sv
// Checker: bus answers and flag reactions at the alarm block's ports.
// Assumes single word transfers; level registers are mirrored from bus writes.
`timescale 1ns/1ns
module capacity_alarm_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic low_capacity_flag,
   input wire logic final_capacity_flag
);
   logic dv_reg, dw_reg, lf, ff, cw, sr;
   logic [7:0] da_reg;
   logic [15:0] low_reg, fs_reg, fc_reg, v;
   // Short names for the flags, the written value and the data phase events
   assign lf = low_capacity_flag;
   assign ff = final_capacity_flag;
   assign v = hwdata[15:0];
   assign cw = dv_reg && dw_reg && da_reg == capacity_alarm_pkg::charge_off;
   assign sr = dv_reg && !dw_reg && da_reg == capacity_alarm_pkg::status_off;
   // Track the data phase and mirror the three level registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dv_reg <= 1'b0;
         dw_reg <= 1'b0;
         da_reg <= 8'h00;
         low_reg <= capacity_alarm_pkg::low_set_rst;
         fs_reg <= capacity_alarm_pkg::final_set_rst;
         fc_reg <= capacity_alarm_pkg::final_clear_rst;
      end else begin
         dv_reg <= hsel && hready && htrans[1];
         dw_reg <= hwrite;
         da_reg <= haddr[7:0];
         if (dv_reg && dw_reg && da_reg == 8'h04) low_reg <= v;
         if (dv_reg && dw_reg && da_reg == 8'h08) fs_reg <= v;
         if (dv_reg && dw_reg && da_reg == 8'h0C) fc_reg <= v;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout) else $error("wait state seen");
   a_resp_okay: assert property (!hresp) else $error("error response seen");
   // A charge write lands at the end of its data phase; the flags follow one edge later
   a_low_sets: assert property (cw && v < low_reg |=> ##1 lf)
      else $error("low flag not set");
   a_low_clears: assert property (cw && v > low_reg |=> ##1 !lf)
      else $error("low flag not cleared");
   a_final_sets: assert property (cw && v < fs_reg && fs_reg != 16'hFFFF
      && !(ff && v > fc_reg) |=> ##1 ff) else $error("final flag not set");
   a_final_disabled: assert property (fs_reg == 16'hFFFF && !ff |=> !ff)
      else $error("disabled final flag set");
   a_final_clears: assert property (cw && ff && v > fc_reg |=> ##1 !ff)
      else $error("final flag not cleared");
   a_final_holds: assert property (cw && ff && v <= fc_reg |=> ##1 ff)
      else $error("final flag dropped early");
   a_status_bits: assert property (sr |-> hrdata[1:0] == $past({ff, lf}))
      else $error("status bits differ from flags");
   a_reset_clear: assert property ($rose(hresetn) |-> !lf && !ff)
      else $error("flag set after reset");
   c_low_set: cover property (cw && v < low_reg);
   c_final_set: cover property (cw && v < fs_reg && fs_reg != 16'hFFFF);
   c_status_final: cover property (sr && hrdata[1]);
endmodule
bind capacity_alarm_flags capacity_alarm_chk capacity_alarm_chk_inst (.hclk, .hresetn,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .low_capacity_flag, .final_capacity_flag);

// ### verif/host_master.sv
// Host model: AHB-Lite master doing single word transfers to the gauge.
// Assumes hready is the slave's hreadyout; the bench watchdog bounds waits.
`timescale 1ns/1ns
module host_master (
   input wire logic hclk,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Address phase, then data phase, each held until hready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d; // Released data no longer shows the last word
   endtask
endmodule

// ### verif/tb_top.sv
// Bench: register resets, corner and random charge values, step counting.
// Assumes host_master drives the bus; the sense pins are driven here.
`timescale 1ns/1ns
module tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic pos_in = 1'b0;
   logic neg_in = 1'b0;
   logic hsel, hwrite, hready, hresp, low_f, fin_f, el, ef, ed;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] lo, fs, fc;
   int mismatches = 0;
   int total_checks = 0;
   always #10 hclk = ~hclk;
   host_master host_master_inst (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata);
   capacity_alarm_flags capacity_alarm_flags_inst (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
      .sense_positive_input(pos_in), .sense_negative_input(neg_in),
      .low_capacity_flag(low_f), .final_capacity_flag(fin_f));
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
      chk_word({29'h0, got}, {29'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_master_inst.xfer(1'b1, a, d, rd);
   endtask
   task automatic rdw(input logic [7:0] a);
      host_master_inst.xfer(1'b0, a, 32'h0, rd);
   endtask
   // Expected flags after one update of the remaining charge
   task automatic apply(input logic [15:0] v);
      if (v < lo) el = 1'b1;
      else if (v > lo) el = 1'b0;
      if (ef && v > fc) ef = 1'b0;
      else if (fs != 16'hFFFF && v < fs) ef = 1'b1;
   endtask
   task automatic check_state(input logic [15:0] v);
      rdw(8'h14);
      chk_flag(rd[2:0], {ed, ef, el});
      // Flag pins are settled here: no update is in flight after the read
      chk_flag({1'b0, fin_f, low_f}, {1'b0, ef, el});
      rdw(8'h10);
      chk_word(rd, {16'h0, v});
   endtask
   task automatic drive(input logic p, input logic n, input int c);
      @(posedge hclk);
      pos_in <= p;
      neg_in <= n;
      repeat (c) @(posedge hclk);
      pos_in <= 1'b0;
      neg_in <= 1'b0;
      repeat (8) @(posedge hclk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog: 10000 cycles, more than ten times the expected run length
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
   initial begin
      logic [31:0] rv [8] = '{32'h0, 32'h96, 32'h4B, 32'h64, 32'h0, 32'h0, 32'h100, 32'h0};
      logic [15:0] cv [8] = '{16'h97, 16'h95, 16'h96, 16'h97, 16'h4A, 16'h64, 16'h65, 16'h3C};
      logic [15:0] v;
      int r;
      r = $urandom(6);
      lo = 16'h0096;
      fs = 16'h004B;
      fc = 16'h0064;
      el = 1'b0;
      ef = 1'b0;
      ed = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rv[i]) begin
         rdw(8'(i * 4));
         chk_word(rd, rv[i]);
      end
      $display("test reset_values done");
      for (int i = 0; i < 48; i++) begin
         if (i == 16) begin
            wr(8'h08, 32'hFFFF);
            fs = 16'hFFFF;
         end
         if (i == 32) begin
            fs = 16'h004B;
            lo = 16'($urandom_range(200, 50));
            wr(8'h08, {16'h0, fs});
            wr(8'h04, {16'h0, lo});
         end
         v = (i < 8) ? cv[i] : 16'($urandom_range(200, 0));
         wr(8'h10, {16'h0, v});
         apply(v);
         check_state(v);
      end
      $display("test charge_writes done");
      wr(8'h18, 32'h1);
      wr(8'h00, 32'h1);
      wr(8'h10, 32'hC8);
      apply(16'hC8);
      // 88 samples make five steps up and leave 8 samples in the integrator
      drive(1'b1, 1'b0, 88);
      ed = 1'b1;
      for (int k = 201; k <= 205; k++) apply(16'(k));
      check_state(16'hCD);
      wr(8'h04, 32'hCB);
      lo = 16'h00CB;
      // 24 samples drain the leftover and make one step down, then 16 per step
      drive(1'b0, 1'b1, 56);
      ed = 1'b0;
      for (int k = 204; k >= 202; k--) apply(16'(k));
      check_state(16'hCA);
      wr(8'h10, 32'h1);
      apply(16'h1);
      drive(1'b0, 1'b1, 52);
      apply(16'h0);
      check_state(16'h0);
      $display("test step_counting done");
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdw(8'h14);
      chk_word(rd, 32'h0);
      $display("test second_reset done");
      summarize();
   end
endmodule
